//--- rtl/xbsw_pkg.sv
/*
  Constants, region table and address decoder for the crossbar switch.
  Assumes a single 50 MHz clock shared by every master and target port.
*/
package xbsw_pkg;
  localparam int NUM_M = 5;
  localparam int NUM_T = 5;
  localparam int AW = 32;
  localparam int DW = 32;

  // Master port indices.
  localparam logic [2:0] M_CPU = 3'h0;
  localparam logic [2:0] M_PF = 3'h1;
  localparam logic [2:0] M_HI = 3'h2;
  localparam logic [2:0] M_LO = 3'h3;
  localparam logic [2:0] M_HOST = 3'h4;

  // Target group indices.
  localparam logic [2:0] T_MEM = 3'h0;
  localparam logic [2:0] T_EXTERNAL_MEMORY_INTERFACE = 3'h1;
  localparam logic [2:0] T_PCFG = 3'h2;
  localparam logic [2:0] T_AUDIO = 3'h3;
  localparam logic [2:0] T_DMA = 3'h4;

  // Masters from highest to lowest priority.
  localparam logic [2:0] PRIO [NUM_M] = '{M_CPU, M_HI, M_LO, M_HOST, M_PF};

  // Bridge reset control register.
  localparam logic [31:0] BRIDGE_CTRL_ADDR = 32'h4000_0024;
  localparam int BRIDGE_RST_BIT = 0;
  localparam logic BRIDGE_RST_RESET = 1'b1;

  // Memory configuration register whose top byte takes byte writes.
  localparam logic [31:0] SDRAM_CONFIG_REGISTER_ADDR = 32'hF000_0008;
  localparam logic [3:0] BE_TOP_BYTE = 4'h8;
  localparam logic [3:0] BE_WORD = 4'hF;

  // Decoded regions: base, end, target, word-only flag.
  localparam int NUM_RGN = 25;
  localparam logic [31:0] RGN_BASE [NUM_RGN] = '{
    32'h0000_0000, 32'h0004_0000, 32'h1000_0000,
    32'h4000_0000, 32'h4100_0000, 32'h4200_0000, 32'h4300_0000,
    32'h4400_0000, 32'h4500_0000, 32'h4600_0000, 32'h4700_0000,
    32'h4800_0000, 32'h4900_0000, 32'h4A00_0000,
    32'h5400_0000, 32'h5500_0000, 32'h5600_0000,
    32'h6000_0000, 32'h6100_8000, 32'h6100_80A0, 32'h6200_8000,
    32'h6200_80A0, 32'h8000_0000, 32'h9000_0000, 32'hF000_0000};
  localparam logic [31:0] RGN_END [NUM_RGN] = '{
    32'h0003_FFFF, 32'h0005_FFFF, 32'h1003_FFFF,
    32'h4000_0083, 32'h4100_015F, 32'h4200_00A3, 32'h4300_0043,
    32'h4400_02BF, 32'h4500_02BF, 32'h4600_02BF, 32'h4700_007F,
    32'h4800_007F, 32'h4900_007F, 32'h4A00_007F,
    32'h54FF_FFFF, 32'h55FF_FFFF, 32'h56FF_FFFF,
    32'h6000_008F, 32'h6100_807F, 32'h6100_81FF, 32'h6200_807F,
    32'h6200_81FF, 32'h8FFF_FFFF, 32'h9FFF_FFFF, 32'hF000_00BF};
  localparam logic [2:0] RGN_TGT [NUM_RGN] = '{
    T_MEM, T_MEM, T_MEM,
    T_PCFG, T_PCFG, T_PCFG, T_PCFG, T_PCFG, T_PCFG, T_PCFG, T_PCFG,
    T_PCFG, T_PCFG, T_PCFG,
    T_AUDIO, T_AUDIO, T_AUDIO,
    T_DMA, T_DMA, T_DMA, T_DMA, T_DMA, T_EXTERNAL_MEMORY_INTERFACE, T_EXTERNAL_MEMORY_INTERFACE, T_EXTERNAL_MEMORY_INTERFACE};
  localparam logic RGN_WORD [NUM_RGN] = '{
    1'b0, 1'b0, 1'b0,
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
    1'b1, 1'b1, 1'b1,
    1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  typedef enum logic {XBSW_IDLE, XBSW_BUSY} xbsw_state_t;

  // Returns {hit, word_only, target} for an address.
  function automatic logic [4:0] xbsw_decode(input logic [31:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int r = 0; r < NUM_RGN; r++) begin
      if (addr >= RGN_BASE[r] && addr <= RGN_END[r]) begin
        res = {1'b1, RGN_WORD[r], RGN_TGT[r]};
      end
    end
    return res;
  endfunction : xbsw_decode
endpackage : xbsw_pkg

//--- rtl/xbsw_top.sv
/*
  Five-master, five-target crossbar switch with fixed-priority arbiters,
  one-entry bridge stages per target and the bridge reset register.
  Assumes masters hold a request until acknowledged and targets answer
  with a one-cycle acknowledge while the request stands.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Accepts requests from five master ports.
// - Routes each request to one of five targets.
// - Different targets serve different masters concurrently.
// - Same-cycle contenders: highest priority wins, others stall.
// - Owner finishes its access before rearbitration.
// - High DMA port beats low DMA port.
// - Program fetch only to external memory, ranks last.
// - Bridge stage captures request, presents it targetward.
// - CPU data requests pass bridge toward peripherals.
// - DMA and host pass bridge toward on-chip memory.
// - External memory requests pass through their bridge.
// - Bit 0 holds memory bridge reset, resets to 1.
// - Upper control bits reserved, read as zero.
// - Register regions refuse partial writes except config byte.
// - ROM and RAM pages decode to on-chip memory.
// - Control register regions decode to configuration bus.
// - Whole audio data windows decode to audio bus.
// - DMA registers and tables decode to DMA target.
// - External spaces decode to external memory target.
module xbsw_top
  import xbsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [NUM_M-1:0] m_req,
  input wire logic [NUM_M-1:0] m_we,
  input wire logic [NUM_M-1:0][AW-1:0] m_addr,
  input wire logic [NUM_M-1:0][DW-1:0] m_wdata,
  input wire logic [NUM_M-1:0][3:0] m_be,
  output logic [NUM_M-1:0] m_ack,
  output logic [NUM_M-1:0] m_err,
  output logic [NUM_M-1:0][DW-1:0] m_rdata,
  output logic [NUM_T-1:0] t_req,
  output logic [NUM_T-1:0] t_we,
  output logic [NUM_T-1:0][AW-1:0] t_addr,
  output logic [NUM_T-1:0][DW-1:0] t_wdata,
  output logic [NUM_T-1:0][3:0] t_be,
  output logic [NUM_T-1:0][2:0] t_master,
  input wire logic [NUM_T-1:0] t_ack,
  input wire logic [NUM_T-1:0][DW-1:0] t_rdata,
  output logic onchip_bridge_reset
);

  logic [NUM_M-1:0] m_ack_reg;
  logic [NUM_M-1:0] m_err_reg;
  logic [NUM_M-1:0][DW-1:0] m_rdata_reg;
  logic [NUM_M-1:0] m_busy_reg;
  logic [NUM_M-1:0] m_ack_next;
  logic [NUM_M-1:0] m_err_next;
  logic [NUM_M-1:0][DW-1:0] m_rdata_next;
  logic [NUM_M-1:0] m_gnt;
  logic [NUM_M-1:0] elig;
  logic [NUM_M-1:0] ok;
  logic [NUM_M-1:0] m_bad;
  logic [NUM_M-1:0][2:0] m_tgt;
  logic [NUM_T-1:0][NUM_M-1:0] cand;

  xbsw_state_t [NUM_T-1:0] t_state_reg;
  logic [NUM_T-1:0] t_req_reg;
  logic [NUM_T-1:0] t_we_reg;
  logic [NUM_T-1:0][AW-1:0] t_addr_reg;
  logic [NUM_T-1:0][DW-1:0] t_wdata_reg;
  logic [NUM_T-1:0][3:0] t_be_reg;
  logic [NUM_T-1:0][2:0] t_owner_reg;
  logic [NUM_T-1:0] t_int_reg;
  logic [NUM_T-1:0] gvalid;
  logic [NUM_T-1:0][2:0] gsel;
  logic [NUM_T-1:0] t_done;
  logic [NUM_T-1:0] t_kill;
  logic [NUM_T-1:0][DW-1:0] t_res;
  logic bridge_rst_reg;

  assign m_ack = m_ack_reg;
  assign m_err = m_err_reg;
  assign m_rdata = m_rdata_reg;
  assign t_req = t_req_reg;
  assign t_we = t_we_reg;
  assign t_addr = t_addr_reg;
  assign t_wdata = t_wdata_reg;
  assign t_be = t_be_reg;
  assign t_master = t_owner_reg;
  assign onchip_bridge_reset = bridge_rst_reg;

  // Decode every master request and check its access width.
  always_comb begin
    logic [4:0] dec;
    logic word_bad;
    dec = 5'h00;
    word_bad = 1'b0;
    for (int i = 0; i < NUM_M; i++) begin
      dec = xbsw_decode(m_addr[i]);
      m_tgt[i] = dec[2:0];
      // Partial access to a word-only region is refused, except a top-byte access to the config register.
      word_bad = dec[3] && (m_be[i] != BE_WORD) &&
                 !(m_addr[i] == SDRAM_CONFIG_REGISTER_ADDR && m_be[i] == BE_TOP_BYTE);
      ok[i] = dec[4] && !word_bad &&
              !(3'(i) == M_PF && dec[2:0] != T_EXTERNAL_MEMORY_INTERFACE);
      // A master is eligible once, until its acknowledge has passed.
      elig[i] = m_req[i] && !m_busy_reg[i] && !m_ack_reg[i];
      m_bad[i] = elig[i] && !ok[i];
    end
  end

  // Fixed-priority arbiter per target; the scan ends on the best master.
  always_comb begin
    logic [2:0] m;
    m = 3'h0;
    for (int t = 0; t < NUM_T; t++) begin
      gvalid[t] = 1'b0;
      gsel[t] = 3'h0;
      for (int i = 0; i < NUM_M; i++) begin
        cand[t][i] = elig[i] && ok[i] && m_tgt[i] == 3'(t);
      end
      for (int p = NUM_M - 1; p >= 0; p--) begin
        m = PRIO[p];
        if (cand[t][m]) begin
          gvalid[t] = 1'b1;
          gsel[t] = m;
        end
      end
      // Only an idle target arbitrates; memory waits out its bridge reset.
      if (t_state_reg[t] != XBSW_IDLE ||
          (3'(t) == T_MEM && bridge_rst_reg)) begin
        gvalid[t] = 1'b0;
      end
    end
  end

  // Completion, abort and reply data of each bridge stage.
  always_comb begin
    for (int t = 0; t < NUM_T; t++) begin
      t_kill[t] = (3'(t) == T_MEM) && bridge_rst_reg &&
                  t_state_reg[t] == XBSW_BUSY;
      t_done[t] = t_state_reg[t] == XBSW_BUSY && !t_kill[t] &&
                  (t_int_reg[t] || t_ack[t]);
      if (t_int_reg[t]) begin
        t_res[t] = {{(DW-1){1'b0}}, bridge_rst_reg};
      end else begin
        t_res[t] = t_rdata[t];
      end
    end
  end

  // Bridge stages: capture the granted request, hold it until answered.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int t = 0; t < NUM_T; t++) begin
        t_state_reg[t] <= XBSW_IDLE;
        t_req_reg[t] <= 1'b0;
        t_we_reg[t] <= 1'b0;
        t_addr_reg[t] <= 32'h0000_0000;
        t_wdata_reg[t] <= 32'h0000_0000;
        t_be_reg[t] <= 4'h0;
        t_owner_reg[t] <= 3'h0;
        t_int_reg[t] <= 1'b0;
      end
    end else begin
      for (int t = 0; t < NUM_T; t++) begin
        if (t_kill[t] || t_done[t]) begin
          t_state_reg[t] <= XBSW_IDLE;
          t_req_reg[t] <= 1'b0;
          t_int_reg[t] <= 1'b0;
        end else if (gvalid[t]) begin
          t_state_reg[t] <= XBSW_BUSY;
          t_owner_reg[t] <= gsel[t];
          t_we_reg[t] <= m_we[gsel[t]];
          t_addr_reg[t] <= m_addr[gsel[t]];
          t_wdata_reg[t] <= m_wdata[gsel[t]];
          t_be_reg[t] <= m_be[gsel[t]];
          // The control register is answered here, never on the bus.
          if (3'(t) == T_PCFG && m_addr[gsel[t]] == BRIDGE_CTRL_ADDR) begin
            t_int_reg[t] <= 1'b1;
            t_req_reg[t] <= 1'b0;
          end else begin
            t_req_reg[t] <= 1'b1;
          end
        end
      end
    end
  end

  // Route answers back to the owning masters.
  always_comb begin
    for (int i = 0; i < NUM_M; i++) begin
      m_ack_next[i] = m_bad[i];
      m_err_next[i] = m_bad[i];
      m_rdata_next[i] = m_rdata_reg[i];
      m_gnt[i] = 1'b0;
      for (int t = 0; t < NUM_T; t++) begin
        if (t_owner_reg[t] == 3'(i) && (t_done[t] || t_kill[t])) begin
          m_ack_next[i] = 1'b1;
          m_err_next[i] = t_kill[t];
          m_rdata_next[i] = t_res[t];
        end
        if (gvalid[t] && gsel[t] == 3'(i)) begin
          m_gnt[i] = 1'b1;
        end
      end
    end
  end

  // Master-side acknowledge, error, read data and in-flight flags.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      m_ack_reg <= 5'h00;
      m_err_reg <= 5'h00;
      m_busy_reg <= 5'h00;
      for (int i = 0; i < NUM_M; i++) begin
        m_rdata_reg[i] <= 32'h0000_0000;
      end
    end else begin
      m_ack_reg <= m_ack_next;
      m_err_reg <= m_err_next;
      m_rdata_reg <= m_rdata_next;
      for (int i = 0; i < NUM_M; i++) begin
        if (m_ack_next[i]) begin
          m_busy_reg[i] <= 1'b0;
        end else if (m_gnt[i]) begin
          m_busy_reg[i] <= 1'b1;
        end
      end
    end
  end

  // Bridge reset control; only full-word writes reach this register.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bridge_rst_reg <= BRIDGE_RST_RESET;
    end else if (t_done[T_PCFG] && t_int_reg[T_PCFG] &&
                 t_we_reg[T_PCFG] && t_be_reg[T_PCFG] == BE_WORD) begin
      bridge_rst_reg <= t_wdata_reg[T_PCFG][BRIDGE_RST_BIT];
    end
  end

  default clocking xbsw_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // The high DMA port is never passed over for the low one.
  for (genvar g = 0; g < NUM_T; g++) begin : g_chk
    a_hi_over_lo: assert property (
      gvalid[g] && cand[g][M_HI] |-> gsel[g] != M_LO)
      else $error("low DMA port won over high DMA port");
    a_owner_hold: assert property (
      t_state_reg[g] == XBSW_BUSY && !t_done[g] && !t_kill[g] |=>
      t_state_reg[g] == XBSW_BUSY && $stable(t_owner_reg[g]) &&
      $stable(t_addr_reg[g]))
      else $error("owner or address changed during an access");
    a_bridge_capture: assert property (
      gvalid[g] |=> t_state_reg[g] == XBSW_BUSY &&
      t_owner_reg[g] == $past(gsel[g]) && (t_req_reg[g] || t_int_reg[g]))
      else $error("granted request not presented by bridge");
    a_req_drop: assert property (
      t_req_reg[g] && t_ack[g] |=> !t_req_reg[g])
      else $error("target request held past its acknowledge");
    a_ack_return: assert property (
      t_req_reg[g] && t_ack[g] && !t_kill[g] |=>
      m_ack_reg[t_owner_reg[g]] && !m_err_reg[t_owner_reg[g]])
      else $error("target answer not returned to its master");
  end

  // An error is only ever reported together with an acknowledge.
  for (genvar g = 0; g < NUM_M; g++) begin : g_mchk
    a_err_with_ack: assert property (
      m_err_reg[g] |-> m_ack_reg[g])
      else $error("error flag without acknowledge");
  end

  // Program fetch wins external memory only when nobody else asks.
  a_pf_lowest: assert property (
    gvalid[T_EXTERNAL_MEMORY_INTERFACE] && gsel[T_EXTERNAL_MEMORY_INTERFACE] == M_PF |->
    (cand[T_EXTERNAL_MEMORY_INTERFACE] & ~(5'h01 << M_PF)) == 5'h00)
    else $error("program fetch granted over another master");

  // The CPU data port wins a contended configuration bus.
  a_cpu_first: assert property (
    gvalid[T_PCFG] && cand[T_PCFG][M_CPU] |-> gsel[T_PCFG] == M_CPU)
    else $error("highest priority master not granted");

  // Bridge reset keeps the memory target quiet.
  a_bridge_hold: assert property (
    bridge_rst_reg |-> !t_req_reg[T_MEM] && !gvalid[T_MEM])
    else $error("memory target active under bridge reset");

  // Configuration bus only sees full-word accesses.
  a_word_only: assert property (
    t_req_reg[T_PCFG] |-> t_be_reg[T_PCFG] == BE_WORD)
    else $error("partial access reached a word-only region");

  // Refused accesses answer with an error on the next cycle.
  a_refuse_fast: assert property (
    m_bad[M_HOST] |=> m_ack_reg[M_HOST] && m_err_reg[M_HOST])
    else $error("refused access not answered with error");

  // Targets see only addresses of their own regions.
  a_mem_decode: assert property (
    t_req_reg[T_MEM] |-> t_addr_reg[T_MEM] <= 32'h0005_FFFF ||
    t_addr_reg[T_MEM][31:18] == 14'h0400)
    else $error("bad address on memory target");
  a_pcfg_decode: assert property (
    t_req_reg[T_PCFG] |-> t_addr_reg[T_PCFG][31:24] >= 8'h40 &&
    t_addr_reg[T_PCFG][31:24] <= 8'h4A)
    else $error("bad address on configuration bus");
  a_audio_decode: assert property (
    t_req_reg[T_AUDIO] |-> t_addr_reg[T_AUDIO][31:24] >= 8'h54 &&
    t_addr_reg[T_AUDIO][31:24] <= 8'h56)
    else $error("bad address on audio bus");
  a_dma_decode: assert property (
    t_req_reg[T_DMA] |-> t_addr_reg[T_DMA][31:28] == 4'h6)
    else $error("bad address on DMA register target");
  a_external_memory_interface_decode: assert property (
    t_req_reg[T_EXTERNAL_MEMORY_INTERFACE] |-> t_addr_reg[T_EXTERNAL_MEMORY_INTERFACE][31:28] >= 4'h8)
    else $error("bad address on external memory target");

  // One answer per access: a second one needs a request after the first.
  a_ack_once: assert property (
    m_ack_reg[M_CPU] |=> !m_ack_reg[M_CPU] ##1
    ($past(m_req[M_CPU]) || !m_ack_reg[M_CPU]))
    else $error("access acknowledged twice");

  // A stalled master stays pending: no answer and no grant taken yet.
  a_stall_wait: assert property (
    elig[M_LO] && ok[M_LO] && !m_gnt[M_LO] |=>
    !m_ack_reg[M_LO] && !m_busy_reg[M_LO])
    else $error("stalled request answered or lost");

  // A full-word write sets bit 0 of the bridge control register.
  a_bridge_write: assert property (
    t_done[T_PCFG] && t_int_reg[T_PCFG] && t_we_reg[T_PCFG] |=>
    bridge_rst_reg == $past(t_wdata_reg[T_PCFG][BRIDGE_RST_BIT]))
    else $error("bridge reset bit not written");

  // Reading the control register returns bit 0 and zero reserved bits.
  a_ctrl_read: assert property (
    t_done[T_PCFG] && t_int_reg[T_PCFG] && !t_we_reg[T_PCFG] |=>
    m_rdata_reg[t_owner_reg[T_PCFG]] == {31'h0000_0000, bridge_rst_reg})
    else $error("control register read returned wrong data");

endmodule : xbsw_top

`default_nettype wire

//--- verification/xbsw_tb_top.sv
/*
  Self-checking bench for the crossbar switch.
  Assumes the target model sits on all five target ports.
*/
`timescale 1ns/1ps
`default_nettype none

module xbsw_tb_top;
  import xbsw_pkg::*;
  logic mclk;
  logic rst_b;
  logic [3:0] dly;
  logic [NUM_M-1:0] m_req;
  logic [NUM_M-1:0] m_we;
  logic [NUM_M-1:0][AW-1:0] m_addr;
  logic [NUM_M-1:0][DW-1:0] m_wdata;
  logic [NUM_M-1:0][3:0] m_be;
  logic [NUM_M-1:0] m_ack;
  logic [NUM_M-1:0] m_err;
  logic [NUM_M-1:0][DW-1:0] m_rdata;
  logic [NUM_T-1:0] t_req;
  logic [NUM_T-1:0][AW-1:0] t_addr;
  logic [NUM_T-1:0][2:0] t_master;
  logic [NUM_T-1:0] t_we;
  logic [NUM_T-1:0][DW-1:0] t_wdata;
  logic [NUM_T-1:0][3:0] t_be;
  logic [DW+4:0] last_f;
  logic [NUM_T-1:0] t_ack;
  logic [NUM_T-1:0][DW-1:0] t_rdata;
  logic onchip_bridge_reset;
  int fails;
  int n_checks;
  int cyc;
  int last_t;
  int last_m;
  int ack_c [NUM_M];
  int ack_n [NUM_M];
  logic [NUM_M-1:0] err_s;
  logic [DW-1:0] rd_s [NUM_M];
  // Decode table: address and {write, target (7 = refused), enables}.
  localparam logic [31:0] D_ADR [13] = '{32'h1000_0000, 32'h0005_FFFC,
    32'h4A00_007C, 32'h4000_0000, 32'h5412_3450, 32'h56FF_FFFC,
    32'h6000_008C, 32'h6200_81FC, 32'h6100_8080, 32'h9FFF_FFFC,
    32'hF000_0008, 32'hF000_0008, 32'h2000_0000};
  localparam logic [7:0] D_CTL [13] = '{8'h0F, 8'h01, 8'h2F, 8'h71,
    8'hBF, 8'h3F, 8'h4F, 8'hC2, 8'h7F, 8'h1F, 8'h98, 8'hF1, 8'h7F};
  localparam logic [31:0] C_ADR [NUM_M] = '{32'h6000_0000, 32'h8000_0000,
    32'h5400_0000, 32'h4700_0000, 32'h1000_0000};

  xbsw_top dut_u (.mclk(mclk), .rst_b(rst_b), .m_req(m_req), .m_we(m_we),
    .m_addr(m_addr), .m_wdata(m_wdata), .m_be(m_be), .m_ack(m_ack),
    .m_err(m_err), .m_rdata(m_rdata), .t_req(t_req), .t_we(t_we),
    .t_addr(t_addr), .t_wdata(t_wdata), .t_be(t_be), .t_master(t_master),
    .t_ack(t_ack), .t_rdata(t_rdata),
    .onchip_bridge_reset(onchip_bridge_reset));

  xbsw_tgt_model tgt_u (.mclk(mclk), .rst_b(rst_b), .dly(dly),
    .t_req(t_req), .t_addr(t_addr), .t_ack(t_ack), .t_rdata(t_rdata));

  // Free-running clock and cycle count.
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  // Masters drop a request once answered; answers and targets are logged.
  always @(negedge mclk) begin
    for (int m = 0; m < NUM_M; m++) begin
      if (m_ack[m] === 1'b1) begin
        m_req[m] = 1'b0;
        ack_c[m] = cyc;
        ack_n[m]++;
        err_s[m] = m_err[m];
        rd_s[m] = m_rdata[m];
      end
    end
    for (int t = 0; t < NUM_T; t++) begin
      if (t_req[t] === 1'b1) begin
        last_t = t;
        last_m = t_master[t];
        last_f = {t_we[t], t_be[t], t_wdata[t]};
      end
    end
  end

  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic raise(input logic [2:0] m, input logic we,
      input logic [31:0] a, input logic [31:0] wd, input logic [3:0] be);
    m_we[m] = we;
    m_addr[m] = a;
    m_wdata[m] = wd;
    m_be[m] = be;
    ack_n[m] = 0;
    m_req[m] = 1'b1;
  endtask : raise

  task automatic settle();
    for (int k = 0; k < 300 && m_req !== '0; k++) begin
      @(negedge mclk);
      #1;
    end
    if (m_req !== '0) begin
      fails++;
      $display("[ERR] %0t no answer from the switch", $time);
      conclude();
    end
    // One quiet cycle, so the next request never lands in an answer cycle.
    @(negedge mclk);
    #1;
  endtask : settle

  task automatic do1(input logic [2:0] m, input logic we,
      input logic [31:0] a, input logic [31:0] wd, input logic [3:0] be);
    raise(m, we, a, wd, be);
    settle();
  endtask : do1

  // Bridge control register: reset value, write, refused byte write.
  task automatic t_regs();
    chk(onchip_bridge_reset, 1);
    chk(t_req, 0);
    do1(M_CPU, 0, BRIDGE_CTRL_ADDR, 0, BE_WORD);
    chk(rd_s[M_CPU], 1);
    do1(M_CPU, 1, BRIDGE_CTRL_ADDR, 0, BE_WORD);
    chk(onchip_bridge_reset, 0);
    do1(M_CPU, 1, BRIDGE_CTRL_ADDR, 1, 4'h1);
    chk(err_s[M_CPU], 1);
    do1(M_CPU, 0, BRIDGE_CTRL_ADDR, 0, BE_WORD);
    chk(rd_s[M_CPU], 0);
  endtask : t_regs

  // Every target group, region edges, widths and refusals.
  task automatic t_decode();
    logic [7:0] c;
    for (int i = 0; i < 13; i++) begin
      c = D_CTL[i];
      last_t = 7;
      last_m = 7;
      last_f = '0;
      do1(M_HOST, c[7], D_ADR[i], ~D_ADR[i], c[3:0]);
      chk(last_t, c[6:4]);
      chk(err_s[M_HOST], c[6:4] == 3'h7);
      if (c[6:4] != 3'h7) begin
        chk(last_m, M_HOST);
        chk(last_f[DW+4:DW], {c[7], c[3:0]});
      end
      if (c[7] && c[6:4] != 3'h7) begin
        chk(last_f[DW-1:0], ~D_ADR[i]);
      end
      if (!c[7] && c[6:4] != 3'h7) begin
        chk(rd_s[M_HOST], D_ADR[i] ^ 32'h5A5A_5A5A);
      end
    end
  endtask : t_decode

  // All five masters hit external memory in the same cycle.
  task automatic t_prio();
    dly = 4'h3;
    for (int i = 0; i < NUM_M; i++) begin
      raise(i[2:0], 0, 32'h8000_0000 | (i << 2), 0, BE_WORD);
    end
    settle();
    for (int i = 1; i < NUM_M; i++) begin
      chk(ack_c[PRIO[i]] > ack_c[PRIO[i - 1]], 1);
    end
    for (int i = 0; i < NUM_M; i++) begin
      chk(ack_n[i], 1);
    end
  endtask : t_prio

  // Five masters on five different targets finish together.
  task automatic t_conc();
    for (int i = 0; i < NUM_M; i++) begin
      raise(i[2:0], 0, C_ADR[i], 0, BE_WORD);
    end
    settle();
    for (int i = 1; i < NUM_M; i++) begin
      chk(ack_c[i], ack_c[0]);
    end
  endtask : t_conc

  // A later, higher-ranked request waits for the current owner.
  task automatic t_own();
    raise(M_LO, 0, 32'h4700_0000, 0, BE_WORD);
    @(negedge mclk);
    #1;
    raise(M_HI, 0, 32'h4200_0000, 0, BE_WORD);
    settle();
    chk(ack_c[M_LO] < ack_c[M_HI], 1);
    chk(ack_n[M_HI], 1);
  endtask : t_own

  // On-chip memory stalls while the bridge is held in reset.
  task automatic t_stall();
    dly = 4'h0;
    do1(M_CPU, 1, BRIDGE_CTRL_ADDR, 1, BE_WORD);
    chk(onchip_bridge_reset, 1);
    raise(M_HOST, 0, 32'h1000_0010, 0, BE_WORD);
    repeat (10) @(negedge mclk);
    #1;
    chk(ack_n[M_HOST], 0);
    raise(M_CPU, 1, BRIDGE_CTRL_ADDR, 0, BE_WORD);
    settle();
    chk(ack_n[M_HOST], 1);
    chk(err_s[M_HOST], 0);
    do1(M_PF, 0, 32'h4000_0000, 0, BE_WORD);
    chk(err_s[M_PF], 1);
  endtask : t_stall

  // Reset, then the scenarios in turn.
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    dly = 4'h0;
    m_req = '0;
    m_we = '0;
    m_addr = '0;
    m_wdata = '0;
    m_be = '0;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    #1;
    t_regs();
    t_decode();
    t_prio();
    t_conc();
    t_own();
    t_stall();
    conclude();
  end
endmodule : xbsw_tb_top

`default_nettype wire

//--- verification/xbsw_tgt_model.sv
/*
  Target-side model: answers each target port after a set delay.
  Assumes the switch holds t_req and its fields until the acknowledge.
*/
`timescale 1ns/1ps
`default_nettype none

module xbsw_tgt_model
  import xbsw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] dly,
  input wire logic [NUM_T-1:0] t_req,
  input wire logic [NUM_T-1:0][AW-1:0] t_addr,
  output logic [NUM_T-1:0] t_ack,
  output logic [NUM_T-1:0][DW-1:0] t_rdata
);
  logic [NUM_T-1:0][3:0] cnt_reg;

  // Each target waits dly cycles, then acknowledges for one cycle.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      t_ack <= '0;
      t_rdata <= '0;
    end else begin
      for (int t = 0; t < NUM_T; t++) begin
        t_ack[t] <= 1'b0;
        t_rdata[t] <= ~t_rdata[t]; // Data is not held outside the answer.
        if (t_req[t] && !t_ack[t]) begin
          if (cnt_reg[t] >= dly) begin
            t_ack[t] <= 1'b1;
            t_rdata[t] <= t_addr[t] ^ 32'h5A5A_5A5A;
            cnt_reg[t] <= 4'h0;
          end else begin
            cnt_reg[t] <= cnt_reg[t] + 4'h1;
          end
        end
      end
    end
  end
endmodule : xbsw_tgt_model

`default_nettype wire
